// ==== design/oau_defs.svh ====
`ifndef OAU_DEFS_SVH
`define OAU_DEFS_SVH

// address space kinds on the memory side
`define OAU_SPACE_IRAM     4'h1
`define OAU_SPACE_SFR      4'h2
`define OAU_SPACE_XDATA    4'h4
`define OAU_SPACE_CODE     4'h8
`define OAU_SPACE_NONE     4'h0

// direct addresses at or above this byte are special function registers
`define OAU_SFR_BASE       8'h80
// bit-addressable ram starts at this byte
`define OAU_BIT_RAM_BASE   8'h20
// bit number msb splits ram half from register half
`define OAU_BIT_HALF_POS   7
// working register bank select field
`define OAU_BANK_POS       3
`define OAU_BANK_SHIFT     3

// reset values
`define OAU_DATA_POINTER_RST       16'h0000
`define OAU_ACC_RST        8'h00

// cycle counts for the resolve sequence
`define OAU_CYC_SHORT      2'h1
`define OAU_CYC_LONG       2'h2

`endif

// ==== design/oau_pkg.sv ====
package oau_pkg;

	// addressing mode requested by the instruction decoder
	typedef enum logic [7:0] {
		OAU_MODE_DIRECT   = 8'h01,
		OAU_MODE_IND8     = 8'h02,
		OAU_MODE_IND16    = 8'h04,
		OAU_MODE_REG      = 8'h08,
		OAU_MODE_IMPLIED  = 8'h10,
		OAU_MODE_IMM      = 8'h20,
		OAU_MODE_INDEXED  = 8'h40,
		OAU_MODE_BIT      = 8'h80
	} oau_mode_type;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		OAU_ST_IDLE  = 3'h1,
		OAU_ST_PTR   = 3'h2,
		OAU_ST_DONE  = 3'h4
	} oau_state_type;

endpackage

// ==== design/oau_bit_map.sv ====
`timescale 1ns/100ps
`include "oau_defs.svh"

// ------------------------------------------------------------
// bit address decode
// ------------------------------------------------------------
module oau_bit_map (
	// bit number from the instruction
	input  wire logic [7:0] bit_num,
	// byte address and bit position
	output logic      [7:0] byte_addr,
	output logic      [2:0] bit_pos,
	output logic            in_sfr
);

	// lower half lands in ram, upper half in register bytes at multiples of eight
	always_comb
	begin
		bit_pos = bit_num[2:0];
		in_sfr  = bit_num[`OAU_BIT_HALF_POS];
		if (bit_num[`OAU_BIT_HALF_POS])
			byte_addr = {bit_num[7:3], 3'h0};
		else
			byte_addr = `OAU_BIT_RAM_BASE + {4'h0, bit_num[6:3]};
	end

endmodule

// ==== design/oau_top.sv ====
`timescale 1ns/100ps
`include "oau_defs.svh"

module oau_top (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic                 external_reset_pin_n,
	// request from the instruction decoder
	input  wire logic                 req_valid,
	input  wire oau_pkg::oau_mode_type req_mode,
	input  wire logic [7:0]           field_byte,
	input  wire logic [2:0]           reg_index,
	input  wire logic                 ptr_sel,
	input  wire logic                 to_xdata,
	input  wire logic                 acc_is_partner,
	// core state needed to resolve
	input  wire logic [1:0]           bank_sel,
	input  wire logic [7:0]           acc_value,
	input  wire logic [15:0]          data_pointer,
	// read port for the working registers in ram
	output logic      [7:0]           ptr_rd_addr,
	input  wire logic [7:0]           ptr_rd_data,
	// resolved operand
	output logic                      res_valid,
	output logic      [15:0]          res_addr,
	output logic      [3:0]           res_space,
	output logic      [7:0]           res_imm,
	output logic                      res_is_imm,
	output logic      [2:0]           res_bit_pos,
	output logic                      res_is_bit,
	output logic                      res_error
);

	// ------------------------------------------------------------
	// reset combine
	// ------------------------------------------------------------
	// the pull-up is outside; a low pin or rst resets, the pin through a two-flop synchroniser.
	// the sync flops reset to the pin's pulled-up idle level, so releasing rst
	// does not produce a false pin reset that would eat the first requests
	logic rst_all;
	logic pin_meta_r;
	logic pin_sync_r;
	assign rst_all = rst; // async part only from rst
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pin_meta_r <= 1'b1;
			pin_sync_r <= 1'b1;
		end
		else
		begin
			pin_meta_r <= external_reset_pin_n;
			pin_sync_r <= pin_meta_r;
		end
	end
	logic soft_rst;
	assign soft_rst = ~pin_sync_r;

	// reg slot address from bank and index
	function automatic logic [7:0] slot_addr(input logic [1:0] bank, input logic [2:0] idx);
		slot_addr = {3'h0, bank, idx};
	endfunction

	// direct space from the field's msb
	function automatic logic [3:0] direct_space(input logic [7:0] a);
		direct_space = (a >= `OAU_SFR_BASE) ? `OAU_SPACE_SFR : `OAU_SPACE_IRAM;
	endfunction

	// ------------------------------------------------------------
	// bit decode
	// ------------------------------------------------------------
	logic [7:0] bit_byte;
	logic [2:0] bit_pos_w;
	logic       bit_sfr;
	oau_bit_map u_bit (
		.bit_num   (field_byte),
		.byte_addr (bit_byte),
		.bit_pos   (bit_pos_w),
		.in_sfr    (bit_sfr)
	);

	// ------------------------------------------------------------
	// sequencer and result registers
	// ------------------------------------------------------------
	oau_pkg::oau_state_type st_r, st_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [3:0]  space_r, space_nxt;
	logic [7:0]  imm_r, imm_nxt;
	logic        isimm_r, isimm_nxt;
	logic [2:0]  bpos_r, bpos_nxt;
	logic        isbit_r, isbit_nxt;
	logic        valid_r, valid_nxt;
	logic        err_r, err_nxt;
	logic        xd_r, xd_nxt;
	logic [7:0]  prd_r, prd_nxt;

	// OAU_MODE_IND8 takes a second cycle to read the pointer register; OAU_MODE_IND16 resolves in one
	always_comb
	begin
		st_nxt    = st_r;
		addr_nxt  = addr_r;
		space_nxt = space_r;
		imm_nxt   = imm_r;
		isimm_nxt = isimm_r;
		bpos_nxt  = bpos_r;
		isbit_nxt = isbit_r;
		valid_nxt = 1'b0;
		err_nxt   = 1'b0;
		xd_nxt    = xd_r;
		prd_nxt   = prd_r;
		case (st_r)
		oau_pkg::OAU_ST_IDLE:
		begin
			if (req_valid)
			begin
				isimm_nxt = 1'b0;
				isbit_nxt = 1'b0;
				imm_nxt   = 8'h00;
				bpos_nxt  = 3'h0;
				// xdata only with the accumulator and only through a pointer
				if (to_xdata && (!acc_is_partner ||
					!(req_mode == oau_pkg::OAU_MODE_IND8 ||
					req_mode == oau_pkg::OAU_MODE_IND16)))
				begin
					err_nxt   = 1'b1;
					valid_nxt = 1'b1;
					space_nxt = `OAU_SPACE_NONE;
					addr_nxt  = 16'h0000;
				end
				else
				begin
					case (req_mode)
					oau_pkg::OAU_MODE_DIRECT:
					begin
						addr_nxt  = {8'h00, field_byte};
						space_nxt = direct_space(field_byte);
						valid_nxt = 1'b1;
					end
					oau_pkg::OAU_MODE_IND8:
					begin
						prd_nxt = slot_addr(bank_sel, {2'h0, ptr_sel});
						xd_nxt  = to_xdata;
						st_nxt  = oau_pkg::OAU_ST_PTR;
					end
					oau_pkg::OAU_MODE_IND16:
					begin
						addr_nxt  = data_pointer;
						space_nxt = to_xdata ? `OAU_SPACE_XDATA : `OAU_SPACE_CODE;
						valid_nxt = 1'b1;
					end
					oau_pkg::OAU_MODE_REG:
					begin
						addr_nxt  = {8'h00, slot_addr(bank_sel, reg_index)};
						space_nxt = `OAU_SPACE_IRAM;
						valid_nxt = 1'b1;
					end
					oau_pkg::OAU_MODE_IMPLIED:
					begin
						addr_nxt  = 16'h0000;
						space_nxt = `OAU_SPACE_NONE;
						valid_nxt = 1'b1;
					end
					oau_pkg::OAU_MODE_IMM:
					begin
						imm_nxt   = field_byte;
						isimm_nxt = 1'b1;
						space_nxt = `OAU_SPACE_NONE;
						addr_nxt  = 16'h0000;
						valid_nxt = 1'b1;
					end
					oau_pkg::OAU_MODE_INDEXED:
					begin
						addr_nxt  = data_pointer + {8'h00, acc_value};
						space_nxt = `OAU_SPACE_CODE;
						valid_nxt = 1'b1;
					end
					oau_pkg::OAU_MODE_BIT:
					begin
						addr_nxt  = {8'h00, bit_byte};
						space_nxt = bit_sfr ? `OAU_SPACE_SFR : `OAU_SPACE_IRAM;
						bpos_nxt  = bit_pos_w;
						isbit_nxt = 1'b1;
						valid_nxt = 1'b1;
					end
					default:
					begin
						err_nxt   = 1'b1;
						valid_nxt = 1'b1;
						space_nxt = `OAU_SPACE_NONE;
					end
					endcase
				end
			end
		end
		oau_pkg::OAU_ST_PTR:
		begin
			addr_nxt  = {8'h00, ptr_rd_data};
			space_nxt = xd_r ? `OAU_SPACE_XDATA : `OAU_SPACE_IRAM;
			valid_nxt = 1'b1;
			st_nxt    = oau_pkg::OAU_ST_IDLE;
		end
		default:
			st_nxt = oau_pkg::OAU_ST_IDLE;
		endcase
	end

	// registers; the synchronised pin is a clocked reset of st_r, valid_r and err_r only
	always_ff @(posedge clk_sys or posedge rst_all)
	begin
		if (rst_all)
		begin
			st_r    <= oau_pkg::OAU_ST_IDLE;
			addr_r  <= 16'h0000;
			space_r <= `OAU_SPACE_NONE;
			imm_r   <= 8'h00;
			isimm_r <= 1'b0;
			bpos_r  <= 3'h0;
			isbit_r <= 1'b0;
			valid_r <= 1'b0;
			err_r   <= 1'b0;
			xd_r    <= 1'b0;
			prd_r   <= 8'h00;
		end
		else if (soft_rst)
		begin
			st_r    <= oau_pkg::OAU_ST_IDLE;
			valid_r <= 1'b0;
			err_r   <= 1'b0;
		end
		else
		begin
			st_r    <= st_nxt;
			addr_r  <= addr_nxt;
			space_r <= space_nxt;
			imm_r   <= imm_nxt;
			isimm_r <= isimm_nxt;
			bpos_r  <= bpos_nxt;
			isbit_r <= isbit_nxt;
			valid_r <= valid_nxt;
			err_r   <= err_nxt;
			xd_r    <= xd_nxt;
			prd_r   <= prd_nxt;
		end
	end

	// outputs straight from flops
	assign ptr_rd_addr = prd_r;
	assign res_valid   = valid_r;
	assign res_addr    = addr_r;
	assign res_space   = space_r;
	assign res_imm     = imm_r;
	assign res_is_imm  = isimm_r;
	assign res_bit_pos = bpos_r;
	assign res_is_bit  = isbit_r;
	assign res_error   = err_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst || soft_rst);

	a_direct_addr: assert property (
		req_valid && st_r == oau_pkg::OAU_ST_IDLE && !to_xdata &&
		req_mode == oau_pkg::OAU_MODE_DIRECT |=>
		res_valid && res_addr == {8'h00, $past(field_byte)} &&
		res_space != `OAU_SPACE_XDATA)
		else $error("direct result wrong");
	a_ind8_two: assert property (
		req_valid && st_r == oau_pkg::OAU_ST_IDLE &&
		req_mode == oau_pkg::OAU_MODE_IND8 && (!to_xdata || acc_is_partner) |=>
		!res_valid ##1 res_valid)
		else $error("indirect not two cycles");
	a_ptr_slot: assert property (
		st_r == oau_pkg::OAU_ST_PTR |->
		ptr_rd_addr[7:5] == 3'h0 && ptr_rd_addr[2:1] == 2'h0)
		else $error("pointer slot bad");
	a_ind16_data_pointer: assert property (
		req_valid && st_r == oau_pkg::OAU_ST_IDLE && !to_xdata &&
		req_mode == oau_pkg::OAU_MODE_IND16 |=>
		res_addr == $past(data_pointer))
		else $error("data pointer not used");
	a_reg_slot: assert property (
		req_valid && st_r == oau_pkg::OAU_ST_IDLE && !to_xdata &&
		req_mode == oau_pkg::OAU_MODE_REG |=>
		res_addr == {11'h000, $past(bank_sel), $past(reg_index)})
		else $error("register slot wrong");
	a_imm_value: assert property (
		req_valid && st_r == oau_pkg::OAU_ST_IDLE && !to_xdata &&
		req_mode == oau_pkg::OAU_MODE_IMM |=>
		res_is_imm && res_imm == $past(field_byte))
		else $error("immediate wrong");
	a_indexed_sum: assert property (
		req_valid && st_r == oau_pkg::OAU_ST_IDLE && !to_xdata &&
		req_mode == oau_pkg::OAU_MODE_INDEXED |=>
		res_space == `OAU_SPACE_CODE &&
		res_addr == $past(data_pointer) + {8'h00, $past(acc_value)})
		else $error("indexed wrong");
	a_bit_half: assert property (
		res_valid && res_is_bit |-> (res_space == `OAU_SPACE_SFR) == res_addr[7])
		else $error("bit half wrong");
	a_xdata_only: assert property (
		res_valid && res_space == `OAU_SPACE_XDATA |-> !res_error)
		else $error("xdata misuse");
	a_xdata_refused: assert property (
		req_valid && st_r == oau_pkg::OAU_ST_IDLE && to_xdata &&
		!(acc_is_partner && (req_mode == oau_pkg::OAU_MODE_IND8 ||
		req_mode == oau_pkg::OAU_MODE_IND16)) |=>
		res_valid && res_error)
		else $error("external ram misuse not refused");
	a_one_resolve: assert property (
		req_valid && st_r == oau_pkg::OAU_ST_IDLE |-> ##[1:2] res_valid)
		else $error("resolve too slow");

	c_direct: cover property (res_valid && res_space == `OAU_SPACE_SFR);
	c_ind8:   cover property (st_r == oau_pkg::OAU_ST_PTR ##1 res_valid);
	c_bit:    cover property (res_valid && res_is_bit);
	c_err:    cover property (res_error);

endmodule

// ==== test/oau_ram_model.sv ====
`timescale 1ns/100ps

// ------------------------------------------------------------
// working register store behind the pointer read port
// ------------------------------------------------------------
module oau_ram_model (
	// read port
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data
);
	// every slot holds a distinct value so a wrong slot shows up;
	// values stay below the register half so results land in ram
	always_comb
	begin
		rd_data = {1'b0, rd_addr[6:0]} + 8'h30;
	end
endmodule

// ==== test/oau_top_test.sv ====
`timescale 1ns/100ps

// ------------------------------------------------------------
// operand addressing bench
// ------------------------------------------------------------
module oau_top_test;
	// one request and what it must resolve to
	typedef struct {
		logic [7:0]  md;
		logic [7:0]  fb;
		logic [2:0]  ri;
		logic [1:0]  bk;
		logic [2:0]  ctl;
		logic [7:0]  acc;
		logic [15:0] dp;
		logic [15:0] ea;
		logic [3:0]  es;
		logic [3:0]  ef;
	} oau_row_type;
	// ctl is {ptr_sel, to_xdata, acc_is_partner}
	// ef is {address checked, immediate, bit, error}

	logic                  clk_sys;
	logic                  rst;
	logic                  pin_n;
	logic                  req_valid;
	oau_pkg::oau_mode_type req_mode;
	logic [7:0]            field_byte;
	logic [2:0]            reg_index;
	logic                  ptr_sel;
	logic                  to_xdata;
	logic                  acc_is_partner;
	logic [1:0]            bank_sel;
	logic [7:0]            acc_value;
	logic [15:0]           data_pointer;
	logic [7:0]            ptr_rd_addr;
	logic [7:0]            ptr_rd_data;
	logic                  res_valid;
	logic [15:0]           res_addr;
	logic [3:0]            res_space;
	logic [7:0]            res_imm;
	logic                  res_is_imm;
	logic [2:0]            res_bit_pos;
	logic                  res_is_bit;
	logic                  res_error;
	int                    n_errors;
	int                    n_compared;
	oau_row_type           rows[16];

	oau_top DUT (.clk_sys(clk_sys), .rst(rst), .external_reset_pin_n(pin_n),
		.req_valid(req_valid), .req_mode(req_mode), .field_byte(field_byte),
		.reg_index(reg_index), .ptr_sel(ptr_sel), .to_xdata(to_xdata),
		.acc_is_partner(acc_is_partner), .bank_sel(bank_sel), .acc_value(acc_value),
		.data_pointer(data_pointer), .ptr_rd_addr(ptr_rd_addr), .ptr_rd_data(ptr_rd_data),
		.res_valid(res_valid), .res_addr(res_addr), .res_space(res_space),
		.res_imm(res_imm), .res_is_imm(res_is_imm), .res_bit_pos(res_bit_pos),
		.res_is_bit(res_is_bit), .res_error(res_error));

	oau_ram_model ram (.rd_addr(ptr_rd_addr), .rd_data(ptr_rd_data));

	// 20 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// present a request for one edge; the answer is sampled mid-cycle,
	// one cycle later or two for the pointer-register mode
	task automatic run(input oau_row_type r);
		@(posedge clk_sys);
		req_valid      <= 1'b1;
		req_mode       <= oau_pkg::oau_mode_type'(r.md);
		field_byte     <= r.fb;
		reg_index      <= r.ri;
		bank_sel       <= r.bk;
		{ptr_sel, to_xdata, acc_is_partner} <= r.ctl;
		acc_value      <= r.acc;
		data_pointer   <= r.dp;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		if (r.md == 8'h02)
			@(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	// the watchdog counts a hang as a mismatch
	initial
	begin
		#200000;
		n_errors++;
		report_and_stop();
	end

	initial
	begin
		rows = '{
			'{8'h01, 8'h35, 3'h0, 2'h0, 3'h0, 8'h00, 16'h0000, 16'h0035, 4'h1, 4'h8},
			'{8'h01, 8'h90, 3'h0, 2'h0, 3'h0, 8'h00, 16'h0000, 16'h0090, 4'h2, 4'h8},
			'{8'h02, 8'h00, 3'h0, 2'h1, 3'h0, 8'h00, 16'h0000, 16'h0038, 4'h1, 4'h8},
			'{8'h02, 8'h00, 3'h0, 2'h3, 3'h4, 8'h00, 16'h0000, 16'h0049, 4'h1, 4'h8},
			'{8'h04, 8'h00, 3'h0, 2'h0, 3'h3, 8'h00, 16'hBEEF, 16'hBEEF, 4'h4, 4'h8},
			'{8'h08, 8'h00, 3'h5, 2'h2, 3'h0, 8'h00, 16'h0000, 16'h0015, 4'h1, 4'h8},
			'{8'h10, 8'h00, 3'h0, 2'h0, 3'h0, 8'h00, 16'h0000, 16'h0000, 4'h0, 4'h0},
			'{8'h20, 8'h5A, 3'h0, 2'h0, 3'h0, 8'h00, 16'h0000, 16'h0000, 4'h0, 4'h4},
			'{8'h40, 8'h00, 3'h0, 2'h0, 3'h0, 8'h20, 16'hFFF0, 16'h0010, 4'h8, 4'h8},
			'{8'h80, 8'h7F, 3'h0, 2'h0, 3'h0, 8'h00, 16'h0000, 16'h002F, 4'h1, 4'hA},
			'{8'h80, 8'h80, 3'h0, 2'h0, 3'h0, 8'h00, 16'h0000, 16'h0080, 4'h2, 4'hA},
			'{8'h01, 8'h35, 3'h0, 2'h0, 3'h3, 8'h00, 16'h0000, 16'h0000, 4'h0, 4'h1},
			'{8'h02, 8'h00, 3'h0, 2'h0, 3'h3, 8'h00, 16'h0000, 16'h0030, 4'h4, 4'h8},
			'{8'h04, 8'h00, 3'h0, 2'h0, 3'h0, 8'h00, 16'h1234, 16'h1234, 4'h8, 4'h8},
			'{8'h03, 8'h00, 3'h0, 2'h0, 3'h0, 8'h00, 16'h0000, 16'h0000, 4'h0, 4'h1},
			'{8'h04, 8'h00, 3'h0, 2'h0, 3'h2, 8'h00, 16'h1234, 16'h0000, 4'h0, 4'h1}};
		n_errors = 0;
		n_compared = 0;
		rst = 1'b1;
		pin_n = 1'b1;
		req_valid = 1'b0;
		req_mode = oau_pkg::OAU_MODE_DIRECT;
		{field_byte, reg_index, ptr_sel, to_xdata, acc_is_partner} = 14'h0000;
		{bank_sel, acc_value, data_pointer} = 26'h0000000;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk(res_valid, 1'b0);
		chk(res_addr, 16'h0000);
		// ordinary cases, one row each
		foreach (rows[i])
		begin
			run(rows[i]);
			chk(res_valid, 1'b1);
			if (rows[i].ef[3]) chk(res_addr, rows[i].ea);
			if (!rows[i].ef[0]) chk(res_space, rows[i].es);
			chk(res_is_imm, rows[i].ef[2]);
			chk(res_is_bit, rows[i].ef[1]);
			chk(res_error, rows[i].ef[0]);
			if (rows[i].ef[2]) chk(res_imm, rows[i].fb);
			if (rows[i].ef[1]) chk(res_bit_pos, rows[i].fb[2:0]);
			@(negedge clk_sys);
			chk(res_valid, 1'b0);
		end
		// back to back: two direct requests on consecutive edges
		@(posedge clk_sys);
		req_valid  <= 1'b1;
		req_mode   <= oau_pkg::OAU_MODE_DIRECT;
		field_byte <= 8'h35;
		{ptr_sel, to_xdata, acc_is_partner} <= 3'h0;
		@(posedge clk_sys);
		field_byte <= 8'h44;
		@(negedge clk_sys);
		chk(res_addr, 16'h0035);
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(negedge clk_sys);
		chk(res_valid, 1'b1);
		chk(res_addr, 16'h0044);
		// a direct request held into the pointer cycle is ignored
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_mode  <= oau_pkg::OAU_MODE_IND8;
		bank_sel  <= 2'h1;
		@(posedge clk_sys);
		req_mode   <= oau_pkg::OAU_MODE_DIRECT;
		field_byte <= 8'h55;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(negedge clk_sys);
		chk(res_addr, 16'h0038);
		@(negedge clk_sys);
		chk(res_valid, 1'b0);
		chk(res_addr, 16'h0038);
		// pin low blocks requests; released pin serves them again
		@(posedge clk_sys);
		pin_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		run(rows[0]);
		chk(res_valid, 1'b0);
		@(posedge clk_sys);
		pin_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		run(rows[1]);
		chk(res_valid, 1'b1);
		chk(res_addr, 16'h0090);
		report_and_stop();
	end
endmodule
